//--- rtl/adc_monitor_otp.sv
/*
  Housekeeping converter scheduler, limit comparators and the
  one-time-memory defaults loader with its identity/calibration bytes.
  Assumes a synchronous one-time memory read port (one-cycle latency),
  converter pulse events as same-clock pulses and converted results
  in 10 uV / 0.01 C units, presented with a done pulse.
*/
// Contract
// - Averaging time constant is two to the three-bit filter field.
// - Nonzero period field enables automatic measurements, active and sleep.
// - Measure when summed pulse events reach two to period plus three.
// - Nonzero period also forces a measurement about every 400 ms.
// - Automatic boost peak adjust only if period nonzero and hold bit clear.
// - Period zero stops measurements, bias refresh and peak adjust.
// - While disabled, supply-low and overheat flags hold their values.
// - Single-cell: low input against 800 mV plus code times 32.42 mV.
// - Otherwise main input against 1699 mV plus code times 47.66 mV.
// - Overheat trips at 115 C plus 5.55 C times the heat code.
// - Out of reset, programmed values replace listed defaults.
// - Loader copies memory bytes 0x00 to 0x1d into configuration.
// - Unique identifier low byte at 0x20, high byte at 0x21.
// - Grade byte 0x2f: 0 undefined, 1 to 105 C, 2 to 125 C.
// - Charge calibration low load at 0x33, high load at 0x34.
// - Oscillator calibration constant at 0x35.
`timescale 1ns/1ps
`include "amo_regs.svh"
module adc_monitor_otp
  import amo_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `AMO_TIMEOUT_CYC,
  parameter int unsigned CONVERTERS  = 3
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWdata,
  output logic      [7:0]            regRdata,
  output logic                       regRvalid,
  output logic                       regReady,
  output logic      [5:0]            nvmAddr,
  input  wire logic [7:0]            nvmData,
  output logic                       cfgLoadValid,
  output logic      [5:0]            cfgLoadAddr,
  output logic      [7:0]            cfgLoadData,
  input  wire logic [CONVERTERS-1:0] converterEnable,
  input  wire logic [CONVERTERS-1:0] pulseEvent,
  input  wire logic                  boost_peak_hold_fixed,
  input  wire logic                  single_cell_select,
  input  wire logic                  measDone,
  input  wire logic [17:0]           low_voltage_input,
  input  wire logic [17:0]           main_supply_input,
  input  wire logic [15:0]           dieTemp,
  output logic                       measStart,
  output logic      [2:0]            filter_time_constant_sel,
  output logic      [7:0]            filterTau,
  output logic                       autoPeakAdjust,
  output logic                       biasRefresh,
  output logic                       supplyLow,
  output logic                       overheat,
  output logic      [15:0]           uniqueId,
  output logic      [7:0]            tempGrade,
  output logic      [7:0]            charge_cal_low_load,
  output logic      [7:0]            charge_cal_high_load,
  output logic      [7:0]            oscillator_cal_byte
);
  amo_state_t s_r, s_nxt;
  logic [5:0] nvmAddrLag_r;
  logic [7:0] filterTau_r;
  logic       cfgLoadValid_r;
  logic [5:0] cfgLoadAddr_r;
  logic [7:0] cfgLoadData_r;
  logic [2:0] measurePeriodExponent;
  logic [3:0] pulseExp;
  logic [31:0] pulseTarget;
  logic [31:0] pulseSum;
  logic [18:0] supplyThr;
  logic [15:0] heatThr;

  assign measurePeriodExponent = s_r.measCtrl[`AMO_PER_HI:`AMO_PER_LO];
  assign pulseExp = 4'(measurePeriodExponent) + 4'(`AMO_PULSE_EXP_BIAS);
  assign pulseTarget = 32'h1 << pulseExp;

  // --------------------------------------------------------------
  // Summed pulse events of the enabled converters
  // --------------------------------------------------------------
  logic [CONVERTERS-1:0] livePulse;
  genvar gi;
  generate
    for (gi = 0; gi < CONVERTERS; gi++) begin : g_pulse
      assign livePulse[gi] = pulseEvent[gi] & converterEnable[gi];
    end
  endgenerate
  always_comb begin
    pulseSum = 32'h0;
    for (int i = 0; i < CONVERTERS; i++) begin
      pulseSum = pulseSum + 32'(livePulse[i]);
    end
  end

  // Limits in fixed-point hundredths of mV / degree
  // One bit wider than the inputs: top main-supply codes exceed 18 bits,
  // and a wrapped threshold would silently clear the flag
  assign supplyThr = single_cell_select ?
    19'(`AMO_VA_BASE + `AMO_VA_STEP *
        int'(s_r.limits[`AMO_VLIM_HI:`AMO_VLIM_LO])) :
    19'(`AMO_VB_BASE + `AMO_VB_STEP *
        int'(s_r.limits[`AMO_VLIM_HI:`AMO_VLIM_LO]));
  assign heatThr = 16'(`AMO_T_BASE + `AMO_T_STEP *
        int'(s_r.limits[`AMO_TLIM_HI:`AMO_TLIM_LO]));

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb begin
    logic autoOn;
    logic [31:0] cnt;
    autoOn = 1'b0;
    cnt = 32'h0;
    s_nxt = s_r;
    s_nxt.rdValid = 1'b0;
    s_nxt.measStart = 1'b0;
    s_nxt.biasRefresh = 1'b0;
    case (s_r.phase)
      AMO_LOAD: begin
        // Address issued last cycle returns now
        s_nxt.nvmAddr = s_r.nvmAddr + 6'h1;
        case (nvmAddrLag_r)
          `AMO_NVM_MEAS_CTRL:  s_nxt.measCtrl = nvmData;
          `AMO_NVM_LIMITS:     s_nxt.limits = nvmData;
          `AMO_NVM_UID_LO:     s_nxt.uniqueId[7:0] = nvmData;
          `AMO_NVM_UID_HI:     s_nxt.uniqueId[15:8] = nvmData;
          `AMO_NVM_TEMP_GRADE: s_nxt.tempGrade = nvmData;
          `AMO_NVM_CAL_LOW:    s_nxt.calLow = nvmData;
          `AMO_NVM_CAL_HIGH:   s_nxt.calHigh = nvmData;
          `AMO_NVM_OSC_CAL: begin
            s_nxt.oscCal = nvmData;
            s_nxt.phase = AMO_RUN;
            s_nxt.ready = 1'b1;
          end
          default: ;
        endcase
      end
      AMO_RUN: begin
        if (regWrite) begin
          if (regAddr == `AMO_MEAS_CTRL_OFS)
            s_nxt.measCtrl = regWdata;
          if (regAddr == `AMO_LIMITS_OFS)
            s_nxt.limits = regWdata;
        end
        if (regRead) begin
          s_nxt.rdValid = 1'b1;
          case (regAddr)
            `AMO_MEAS_CTRL_OFS: s_nxt.rdData = s_r.measCtrl;
            `AMO_LIMITS_OFS:    s_nxt.rdData = s_r.limits;
            default:            s_nxt.rdData = 8'h00;
          endcase
        end
        autoOn = (measurePeriodExponent != 3'h0);
        s_nxt.autoPeakAdj = autoOn & ~boost_peak_hold_fixed;
        if (!autoOn) begin
          s_nxt.pulseCnt = 32'h0;
          s_nxt.timer = 32'h0;
        end else begin
          cnt = s_r.pulseCnt + pulseSum;
          if (cnt >= pulseTarget ||
              s_r.timer >= TIMEOUT_CYC - 1) begin
            s_nxt.measStart = 1'b1;
            s_nxt.pulseCnt = 32'h0;
            s_nxt.timer = 32'h0;
          end else begin
            s_nxt.pulseCnt = cnt;
            s_nxt.timer = s_r.timer + 32'h1;
          end
        end
        // Results landing after a disable are dropped
        if (autoOn && measDone) begin
          s_nxt.biasRefresh = 1'b1;
          s_nxt.supplyLow = 19'(single_cell_select ?
            low_voltage_input : main_supply_input) < supplyThr;
          s_nxt.overheat = dieTemp >= heatThr;
        end
      end
      default: s_nxt.phase = AMO_LOAD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.phase <= AMO_LOAD;
      s_r.measCtrl <= `AMO_MEAS_CTRL_RST;
      s_r.limits <= `AMO_LIMITS_RST;
      nvmAddrLag_r <= 6'h3f;
      filterTau_r <= 8'h01;
      cfgLoadValid_r <= 1'b0;
      cfgLoadAddr_r <= 6'h0;
      cfgLoadData_r <= 8'h0;
    end else begin
      s_r <= s_nxt;
      nvmAddrLag_r <= (s_r.phase == AMO_LOAD) ? s_r.nvmAddr : 6'h3f;
      filterTau_r <= 8'h01 << s_nxt.measCtrl[`AMO_TAU_HI:`AMO_TAU_LO];
      // Forward every configuration byte to the other register owners
      cfgLoadValid_r <= (s_r.phase == AMO_LOAD) &&
                        (nvmAddrLag_r <= `AMO_NVM_LOAD_LAST);
      cfgLoadAddr_r <= nvmAddrLag_r;
      cfgLoadData_r <= nvmData;
    end
  end

  assign nvmAddr = s_r.nvmAddr;
  assign regRdata = s_r.rdData;
  assign regRvalid = s_r.rdValid;
  assign regReady = s_r.ready;
  assign cfgLoadValid = cfgLoadValid_r;
  assign cfgLoadAddr = cfgLoadAddr_r;
  assign cfgLoadData = cfgLoadData_r;
  assign measStart = s_r.measStart;
  assign filter_time_constant_sel = s_r.measCtrl[`AMO_TAU_HI:`AMO_TAU_LO];
  assign filterTau = filterTau_r;
  assign autoPeakAdjust = s_r.autoPeakAdj;
  assign biasRefresh = s_r.biasRefresh;
  assign supplyLow = s_r.supplyLow;
  assign overheat = s_r.overheat;
  assign uniqueId = s_r.uniqueId;
  assign tempGrade = s_r.tempGrade;
  assign charge_cal_low_load = s_r.calLow;
  assign charge_cal_high_load = s_r.calHigh;
  assign oscillator_cal_byte = s_r.oscCal;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  peak_gate_a: assert property (@(posedge clk) disable iff (srst)
    s_r.phase == AMO_RUN |=> autoPeakAdjust ==
      (($past(measurePeriodExponent) != 3'h0) &&
       !$past(boost_peak_hold_fixed)))
    else $error("peak adjust gate wrong");
  idle_quiet_a: assert property (@(posedge clk) disable iff (srst)
    measurePeriodExponent == 3'h0 && s_r.phase == AMO_RUN
      |=> !measStart && !biasRefresh)
    else $error("activity while disabled");
  flags_hold_a: assert property (@(posedge clk) disable iff (srst)
    measurePeriodExponent == 3'h0 |=> $stable(supplyLow) && $stable(overheat))
    else $error("flags moved while disabled");
  tau_track_a: assert property (@(posedge clk) disable iff (srst)
    filterTau == (8'h01 << filter_time_constant_sel))
    else $error("filter constant wrong");
  ready_late_a: assert property (@(posedge clk) disable iff (srst)
    regReady |-> s_r.phase == AMO_RUN)
    else $error("ready before load done");
  timeout_cap_a: assert property (@(posedge clk) disable iff (srst)
    s_r.timer < TIMEOUT_CYC)
    else $error("timeout overran");
  pulse_fire_a: assert property (@(posedge clk) disable iff (srst)
    s_r.phase == AMO_RUN && measurePeriodExponent != 3'h0 &&
    s_r.pulseCnt + pulseSum >= pulseTarget |=> measStart)
    else $error("pulse trigger missed");
  load_range_a: assert property (@(posedge clk) disable iff (srst)
    cfgLoadValid |-> cfgLoadAddr <= `AMO_NVM_LOAD_LAST)
    else $error("copy outside config range");
endmodule // adc_monitor_otp

//--- rtl/amo_pkg.sv
/*
  Types for the housekeeping converter control block.
  Assumes amo_regs.svh is on the include path.
*/
package amo_pkg;
  typedef enum logic [1:0] {AMO_LOAD, AMO_RUN} amo_phase_t;
  typedef struct packed {
    amo_phase_t  phase;
    logic [5:0]  nvmAddr;
    logic [7:0]  measCtrl;
    logic [7:0]  limits;
    logic [7:0]  rdData;
    logic        rdValid;
    logic        ready;
    logic [31:0] pulseCnt;
    logic [31:0] timer;
    logic        measStart;
    logic        supplyLow;
    logic        overheat;
    logic        autoPeakAdj;
    logic        biasRefresh;
    logic [15:0] uniqueId;
    logic [7:0]  tempGrade;
    logic [7:0]  calLow;
    logic [7:0]  calHigh;
    logic [7:0]  oscCal;
    logic        p1;
    logic        p2;
  } amo_state_t;
endpackage

//--- rtl/amo_regs.svh
/*
  Register offsets, field positions, reset values and timing counts
  for the housekeeping converter control block.
  Assumes inclusion by the design file and testbench by bare name.
*/
`ifndef AMO_REGS_SVH
`define AMO_REGS_SVH
`define AMO_MEAS_CTRL_OFS     8'h5c
`define AMO_LIMITS_OFS        8'h5d
`define AMO_MEAS_CTRL_RST     8'h00
`define AMO_LIMITS_RST        8'h00
`define AMO_RSVD_HI           7
`define AMO_RSVD_LO           6
`define AMO_TAU_HI            5
`define AMO_TAU_LO            3
`define AMO_PER_HI            2
`define AMO_PER_LO            0
`define AMO_VLIM_HI           7
`define AMO_VLIM_LO           3
`define AMO_TLIM_HI           2
`define AMO_TLIM_LO           0
`define AMO_PULSE_EXP_BIAS    3
`define AMO_NVM_MEAS_CTRL     6'h1c
`define AMO_NVM_LIMITS        6'h1d
`define AMO_NVM_LOAD_LAST     6'h1d
`define AMO_NVM_UID_LO        6'h20
`define AMO_NVM_UID_HI        6'h21
`define AMO_NVM_TEMP_GRADE    6'h2f
`define AMO_NVM_PART_CODE     6'h30
`define AMO_NVM_PART_REV      6'h31
`define AMO_NVM_CAL_LOW       6'h33
`define AMO_NVM_CAL_HIGH      6'h34
`define AMO_NVM_OSC_CAL       6'h35
`define AMO_TIMEOUT_MS        400
`define AMO_CLK_KHZ           200000
`define AMO_TIMEOUT_CYC       (`AMO_TIMEOUT_MS * `AMO_CLK_KHZ)
// Low-limit scaled in 10 uV, temperature in 0.01 C
`define AMO_VA_BASE           80000
`define AMO_VA_STEP           3242
`define AMO_VB_BASE           169900
`define AMO_VB_STEP           4766
`define AMO_T_BASE            11500
`define AMO_T_STEP            555
`define AMO_GRADE_UNDEF       8'h00
`define AMO_GRADE_105         8'h01
`define AMO_GRADE_125         8'h02
`endif

//--- verification/tb.sv
/*
  Self-checking bench for adc_monitor_otp: loader, registers, scheduler.
  Assumes amo_pkg is compiled first and amo_regs.svh is on the include path.
*/
`timescale 1ns/1ps
`include "amo_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb
  import amo_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clk = 0, srst = 1, regWrite = 0, regRead = 0;
  logic [7:0]  regAddr = 0, regWdata = 0, nvmData = 0, regRdata;
  logic        regRvalid, regReady, cfgLoadValid, measStart, measDone = 0;
  logic [5:0]  nvmAddr, cfgLoadAddr, loadCnt = 0;
  logic [7:0]  cfgLoadData, filterTau, tempGrade, oscillator_cal_byte;
  logic [7:0]  charge_cal_low_load, charge_cal_high_load;
  logic [2:0]  converterEnable = 3'h3, pulseEvent = 0, filter_time_constant_sel;
  logic        boost_peak_hold_fixed = 0, single_cell_select = 0;
  logic [17:0] low_voltage_input = 0, main_supply_input = 0;
  logic [15:0] dieTemp = 0, uniqueId;
  logic        autoPeakAdjust, biasRefresh, supplyLow, overheat;
  logic [7:0]  mem [64];
  logic [7:0]  expQ [$];
  logic [7:0]  expRd;
  int          error_cnt = 0, checks_done = 0, measCnt = 0, biasCnt = 0;
  int          n, m, b, sum;
  logic [2:0]  p;

  adc_monitor_otp #(.TIMEOUT_CYC(200), .CONVERTERS(3)) u_adc_monitor_otp (
    .clk, .srst, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
    .regRvalid, .regReady, .nvmAddr, .nvmData, .cfgLoadValid, .cfgLoadAddr,
    .cfgLoadData, .converterEnable, .pulseEvent, .boost_peak_hold_fixed,
    .single_cell_select, .measDone, .low_voltage_input, .main_supply_input,
    .dieTemp, .measStart, .filter_time_constant_sel, .filterTau,
    .autoPeakAdjust, .biasRefresh, .supplyLow, .overheat, .uniqueId,
    .tempGrade, .charge_cal_low_load, .charge_cal_high_load,
    .oscillator_cal_byte);

  always #2.5 clk = ~clk;

  // One-cycle read latency, like the real fuse array
  always @(posedge clk) nvmData <= mem[nvmAddr];

  // ----------------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (regRvalid === 1'b1) begin
      expRd = expQ.pop_front();
      `CHK(regRdata, expRd)
    end
    if (cfgLoadValid === 1'b1) begin
      `CHK(cfgLoadAddr, loadCnt)
      `CHK(cfgLoadData, mem[cfgLoadAddr])
      loadCnt = loadCnt + 6'h01;
    end
    if (measStart === 1'b1) measCnt++;
    if (biasRefresh === 1'b1) biasCnt++;
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    regWrite <= 1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 0;
  endtask

  task automatic rd(input logic [7:0] a, e);
    expQ.push_back(e);
    @(posedge clk);
    regRead <= 1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 0;
  endtask

  task automatic meas(input logic [17:0] a, v, input logic [15:0] t);
    @(posedge clk);
    measDone <= 1;
    low_voltage_input <= a;
    main_supply_input <= v;
    dieTemp <= t;
    @(posedge clk);
    measDone <= 0;
    step(2);
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole run is under a thousand cycles
  initial begin
    #100us;
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h39b41503));
    foreach (mem[i]) mem[i] = 8'($urandom);
    mem[`AMO_NVM_MEAS_CTRL] = {2'b00, mem[`AMO_NVM_MEAS_CTRL][5:0]};
    mem[`AMO_NVM_TEMP_GRADE] = `AMO_GRADE_125;
    repeat (16) @(posedge clk);
    srst <= 0;
    step(1);
    `CHK(regReady, 1'b0)
    // Write during the load must be dropped
    wr(`AMO_MEAS_CTRL_OFS, 8'h3f);
    n = 0;
    while (regReady !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    `CHK(loadCnt, 6'd30)
    `CHK(uniqueId, {mem[`AMO_NVM_UID_HI], mem[`AMO_NVM_UID_LO]})
    `CHK(tempGrade, `AMO_GRADE_125)
    `CHK(charge_cal_low_load, mem[`AMO_NVM_CAL_LOW])
    `CHK(charge_cal_high_load, mem[`AMO_NVM_CAL_HIGH])
    `CHK(oscillator_cal_byte, mem[`AMO_NVM_OSC_CAL])
    `CHK(filter_time_constant_sel, mem[`AMO_NVM_MEAS_CTRL][5:3])
    rd(`AMO_MEAS_CTRL_OFS, mem[`AMO_NVM_MEAS_CTRL]);
    rd(`AMO_LIMITS_OFS, mem[`AMO_NVM_LIMITS]);
    wr(8'h77, 8'hff);
    rd(8'h77, 8'h00);
    for (int t = 0; t < 8; t++) begin
      wr(`AMO_MEAS_CTRL_OFS, {2'b00, 3'(t), 3'h1});
      step(2);
      `CHK(filter_time_constant_sel, 3'(t))
      `CHK(filterTau, 8'(1 << t))
      rd(`AMO_MEAS_CTRL_OFS, {2'b00, 3'(t), 3'h1});
    end
    wr(`AMO_LIMITS_OFS, {5'd5, 3'd2});
    rd(`AMO_LIMITS_OFS, {5'd5, 3'd2});
    step(2);
    `CHK(autoPeakAdjust, 1'b1)
    @(posedge clk);
    boost_peak_hold_fixed <= 1;
    step(2);
    `CHK(autoPeakAdjust, 1'b0)
    @(posedge clk);
    boost_peak_hold_fixed <= 0;
    // Align to a fresh measurement so the timer cannot fire mid-count
    m = measCnt;
    n = 0;
    while (measCnt == m && n < 300) begin
      step(1);
      n++;
    end
    m = measCnt;
    sum = 0;
    while (sum < 16) begin
      p = 3'($urandom);
      sum += $countones(p & converterEnable);
      @(posedge clk);
      pulseEvent <= p;
      #1 `CHK(measCnt, m)
    end
    @(posedge clk);
    pulseEvent <= 0;
    step(4);
    `CHK(measCnt, m + 1)
    m = measCnt;
    n = 0;
    while (measCnt == m && n < 400) begin
      step(1);
      n++;
    end
    `CHK(n >= 190 && n <= 210, 1'b1)
    b = biasCnt;
    @(posedge clk);
    single_cell_select <= 1;
    meas(18'd96209, 18'd0, 16'd12610);
    `CHK({supplyLow, overheat}, 2'b11)
    meas(18'd96210, 18'd0, 16'd12609);
    `CHK({supplyLow, overheat}, 2'b00)
    @(posedge clk);
    single_cell_select <= 0;
    // Top code lies above any 18-bit input: flag must be set
    wr(`AMO_LIMITS_OFS, {5'd31, 3'd2});
    meas(18'd0, 18'h3ffff, 16'd0);
    `CHK(supplyLow, 1'b1)
    wr(`AMO_LIMITS_OFS, {5'd5, 3'd2});
    meas(18'd0, 18'd193729, 16'd0);
    `CHK(supplyLow, 1'b1)
    meas(18'd0, 18'd193730, 16'd0);
    `CHK(supplyLow, 1'b0)
    `CHK(biasCnt, b + 5)
    wr(`AMO_MEAS_CTRL_OFS, 8'h38);
    m = measCnt;
    b = biasCnt;
    meas(18'd0, 18'd0, 16'hffff);
    `CHK({supplyLow, overheat}, 2'b00)
    @(posedge clk);
    converterEnable <= 3'h7;
    pulseEvent <= 3'h7;
    repeat (250) @(posedge clk);
    pulseEvent <= 0;
    #1;
    `CHK(measCnt, m)
    `CHK(biasCnt, b)
    `CHK(autoPeakAdjust, 1'b0)
    step(4);
    `CHK(expQ.size(), 0)
    print_verdict();
  end
endmodule // tb
